// ### logic/event_timestamp_map.vh
// register offsets, field positions, reset values and timing for the sample capture registers
`ifndef EVENT_TIMESTAMP_MAP_VH
`define EVENT_TIMESTAMP_MAP_VH

// register byte offsets
`define SAMPLE7_NANOSECONDS_OFS 16'h059C
`define SAMPLE7_SECONDS_OFS     16'h05A0
`define SAMPLE7_PHASE_OFS       16'h05A4
`define SAMPLE8_NANOSECONDS_OFS 16'h05A8
`define SAMPLE8_SECONDS_OFS     16'h05AC

// unit index pointer position in the global unit index register
`define UNIT_PTR_BIT            8

// nanoseconds register fields
`define NSEC_EDGE_BIT           30
`define NSEC_FIELD_MSB          29
`define NSEC_FIELD_W            30

// seconds and phase fields
`define SEC_FIELD_W             32
`define PHASE_FIELD_W           3

// reset values
`define NSEC_RESET              30'h0000_0000
`define SEC_RESET               32'h0000_0000
`define PHASE_RESET             3'h0
`define EDGE_RESET              1'h0

// slot codes within one base period
`define SLOT_CODE_1ST           3'h0
`define SLOT_CODE_2ND           3'h1
`define SLOT_CODE_3RD           3'h2
`define SLOT_CODE_4TH           3'h3
`define SLOT_CODE_5TH           3'h4

// timing, in nanoseconds
`define CLK_PERIOD_NS           4
`define BASE_PERIOD_NS          40
`define SLOT_PERIOD_NS          8

// recorded sample numbers held here, counted from zero
`define SAMPLE7_INDEX           4'h6
`define SAMPLE8_INDEX           4'h7
`define SAMPLE_COUNT_MAX        4'h8

`endif

// ### logic/capture_sample_slot.v
// one recorded sample: edge direction, nanoseconds, seconds and slot code
`include "event_timestamp_map.vh"

module capture_sample_slot (
    // clock and reset
    input  wire        i_mclk,
    input  wire        i_rst,
    // capture side
    input  wire        i_load,
    input  wire        i_edge,
    input  wire [29:0] i_nsec,
    input  wire [31:0] i_sec,
    input  wire [2:0]  i_phase,
    // held sample
    output reg         o_edge,
    output reg  [29:0] o_nsec,
    output reg  [31:0] o_sec,
    output reg  [2:0]  o_phase
);

    // fields clear at reset and only change on a capture
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_edge  <= `EDGE_RESET;
            o_nsec  <= `NSEC_RESET;
            o_sec   <= `SEC_RESET;
            o_phase <= `PHASE_RESET;
        end else if (i_load) begin
            o_edge  <= i_edge;
            o_nsec  <= i_nsec;
            o_sec   <= i_sec;
            o_phase <= i_phase;
        end
    end

endmodule // capture_sample_slot

// ### logic/event_timestamp_sample_regs.v
// seventh and eighth event timestamp sample registers with unit index selection
//
// Overview of operation
// - unit pointer bit 8 selects presented unit
// - bit 30 reports rising one, falling zero
// - nanoseconds held in bits 29:0
// - seconds held in full 31:0 field
// - phase code names 8ns slot in 40ns
// - eighth sample mirrors seventh nanoseconds and seconds words, own addresses, no phase word
`include "event_timestamp_map.vh"

module event_timestamp_sample_regs #(
    parameter NUM_UNITS = 2
) (
    // clock and reset
    input  wire                 i_mclk,
    input  wire                 i_rst,
    // event inputs, one per timestamp unit, synchronous to i_mclk
    input  wire [NUM_UNITS-1:0] i_event,
    input  wire [NUM_UNITS-1:0] i_rearm,
    // time of day from the time base
    input  wire [29:0]          i_tod_nsec,
    input  wire [31:0]          i_tod_sec,
    // global unit index register value
    input  wire [31:0]          i_unit_index_reg,
    // register access port
    input  wire [15:0]          i_reg_addr,
    input  wire                 i_reg_rd,
    input  wire                 i_reg_wr,
    input  wire [31:0]          i_reg_wdata,
    output reg  [31:0]          o_reg_rdata,
    output reg                  o_reg_rvalid
);

    // cycles per base period and per slot, derived from the clock rate
    localparam [31:0] BASE_CYCLES = (`BASE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [31:0] SLOT_CYCLES = (`SLOT_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [3:0]  BASE_LAST   = BASE_CYCLES[3:0] - 4'h1;
    localparam [3:0]  SLOT_LAST   = SLOT_CYCLES[3:0] - 4'h1;

    // base period divider and slot position
    reg  [3:0] base_cnt_ff;
    reg  [3:0] slot_cnt_ff;
    reg  [2:0] slot_code_ff;

    // per-unit held samples
    wire        s7_edge  [0:NUM_UNITS-1];
    wire [29:0] s7_nsec  [0:NUM_UNITS-1];
    wire [31:0] s7_sec   [0:NUM_UNITS-1];
    wire [2:0]  s7_phase [0:NUM_UNITS-1];
    wire        s8_edge  [0:NUM_UNITS-1];
    wire [29:0] s8_nsec  [0:NUM_UNITS-1];
    wire [31:0] s8_sec   [0:NUM_UNITS-1];

    // read path
    reg  [31:0] nxt_rdata;
    wire        unit_sel;

    // fields of the unit named by the pointer
    wire        sel7_edge;
    wire [29:0] sel7_nsec;
    wire [31:0] sel7_sec;
    wire [2:0]  sel7_phase;
    wire        sel8_edge;
    wire [29:0] sel8_nsec;
    wire [31:0] sel8_sec;

    // writes carry no effect: every field here is read-only
    wire        wr_ignored;
    assign wr_ignored = i_reg_wr & (|i_reg_wdata);

    // divider: ten clocks per 40ns period, slot advances every two clocks
    // free-running from reset, not aligned to the time base's own period
    always @(posedge i_mclk) begin
        if (i_rst) begin
            base_cnt_ff  <= 4'h0;
            slot_cnt_ff  <= 4'h0;
            slot_code_ff <= `SLOT_CODE_1ST;
        end else begin
            if (base_cnt_ff == BASE_LAST) begin
                base_cnt_ff  <= 4'h0;
                slot_cnt_ff  <= 4'h0;
                slot_code_ff <= `SLOT_CODE_1ST;
            end else begin
                base_cnt_ff <= base_cnt_ff + 4'h1;
                if (slot_cnt_ff == SLOT_LAST) begin
                    slot_cnt_ff <= 4'h0;
                    // third slot coded 010; printed 101 collides with reserved codes
                    case (slot_code_ff)
                        `SLOT_CODE_1ST: slot_code_ff <= `SLOT_CODE_2ND;
                        `SLOT_CODE_2ND: slot_code_ff <= `SLOT_CODE_3RD;
                        `SLOT_CODE_3RD: slot_code_ff <= `SLOT_CODE_4TH;
                        `SLOT_CODE_4TH: slot_code_ff <= `SLOT_CODE_5TH;
                        default:        slot_code_ff <= `SLOT_CODE_5TH;
                    endcase
                end else begin
                    slot_cnt_ff <= slot_cnt_ff + 4'h1;
                end
            end
        end
    end

    // per-unit edge detect, sample numbering and the two sample slots
    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u = u + 1) begin : g_unit
            reg        ev_prev_ff;
            reg  [3:0] sample_cnt_ff;
            wire       ev_edge;
            wire       ev_rise;
            wire       load7;
            wire       load8;
            wire       cnt_full;

            assign ev_edge = i_event[u] ^ ev_prev_ff;
            assign ev_rise = i_event[u] & ~ev_prev_ff;
            assign load7   = ev_edge & (sample_cnt_ff == `SAMPLE7_INDEX);
            assign load8   = ev_edge & (sample_cnt_ff == `SAMPLE8_INDEX);
            // eighth sample taken: later events are dropped until a rearm
            assign cnt_full = (sample_cnt_ff == `SAMPLE_COUNT_MAX);

            // counts recorded samples; saturates once the eighth is taken
            always @(posedge i_mclk) begin
                if (i_rst) begin
                    ev_prev_ff    <= 1'h0;
                    sample_cnt_ff <= 4'h0;
                end else begin
                    ev_prev_ff <= i_event[u];
                    if (i_rearm[u]) begin
                        sample_cnt_ff <= 4'h0;
                    end else if (ev_edge && !cnt_full) begin
                        sample_cnt_ff <= sample_cnt_ff + 4'h1;
                    end
                end
            end

            capture_sample_slot u_sample7 (
                .i_mclk  (i_mclk),
                .i_rst   (i_rst),
                .i_load  (load7),
                .i_edge  (ev_rise),
                .i_nsec  (i_tod_nsec),
                .i_sec   (i_tod_sec),
                .i_phase (slot_code_ff),
                .o_edge  (s7_edge[u]),
                .o_nsec  (s7_nsec[u]),
                .o_sec   (s7_sec[u]),
                .o_phase (s7_phase[u])
            );

            // eighth sample uses the same slot for nanoseconds and seconds at its own offsets; its phase is left unconnected
            capture_sample_slot u_sample8 (
                .i_mclk  (i_mclk),
                .i_rst   (i_rst),
                .i_load  (load8),
                .i_edge  (ev_rise),
                .i_nsec  (i_tod_nsec),
                .i_sec   (i_tod_sec),
                .i_phase (slot_code_ff),
                .o_edge  (s8_edge[u]),
                .o_nsec  (s8_nsec[u]),
                .o_sec   (s8_sec[u]),
                .o_phase ()
            );
        end
    endgenerate

    // unit pointer taken straight from the global index register
    assign unit_sel = i_unit_index_reg[`UNIT_PTR_BIT];

    // one mux per field, so the offset decode below stays flat
    assign sel7_edge  = s7_edge[unit_sel];
    assign sel7_nsec  = s7_nsec[unit_sel];
    assign sel7_sec   = s7_sec[unit_sel];
    assign sel7_phase = s7_phase[unit_sel];
    assign sel8_edge  = s8_edge[unit_sel];
    assign sel8_nsec  = s8_nsec[unit_sel];
    assign sel8_sec   = s8_sec[unit_sel];

    // read mux; reserved bits and unmapped offsets return zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (i_reg_addr)
            `SAMPLE7_NANOSECONDS_OFS: begin
                nxt_rdata[`NSEC_EDGE_BIT]       = sel7_edge;
                nxt_rdata[`NSEC_FIELD_MSB:0]    = sel7_nsec;
            end
            `SAMPLE7_SECONDS_OFS: begin
                nxt_rdata = sel7_sec;
            end
            `SAMPLE7_PHASE_OFS: begin
                nxt_rdata[`PHASE_FIELD_W-1:0]   = sel7_phase;
            end
            `SAMPLE8_NANOSECONDS_OFS: begin
                nxt_rdata[`NSEC_EDGE_BIT]       = sel8_edge;
                nxt_rdata[`NSEC_FIELD_MSB:0]    = sel8_nsec;
            end
            `SAMPLE8_SECONDS_OFS: begin
                nxt_rdata = sel8_sec;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // read answer registered one cycle after the strobe
    // a read in the cycle of a capture still returns the older sample
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_reg_rdata  <= 32'h0000_0000;
            o_reg_rvalid <= 1'h0;
        end else begin
            o_reg_rvalid <= i_reg_rd & ~(wr_ignored & 1'h0);
            if (i_reg_rd) begin
                o_reg_rdata <= nxt_rdata;
            end
        end
    end

endmodule // event_timestamp_sample_regs

// ### tb/sample_regs_checker_assertions.sv
// concurrent checks on the sample register read port
module sample_regs_checker (
    // clock and reset
    input wire logic        i_mclk,
    input wire logic        i_rst,
    // register access port
    input wire logic [15:0] i_reg_addr,
    input wire logic        i_reg_rd,
    input wire logic        i_reg_wr,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        o_reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // strobe to answer timing, exactly one cycle
    rvalid_follows_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("no rvalid after read");
    no_stray_valid_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("rvalid without read");
    // data only moves with an answer, so a write cannot disturb it
    rdata_holds_a: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
        else $error("read data changed without read");
    // reserved top bits of both nanosecond words
    nsec7_resv_a: assert property (i_reg_rd && i_reg_addr == 16'h059C |=> !o_reg_rdata[31])
        else $error("bit 31 set in sample 7 ns");
    nsec8_resv_a: assert property (i_reg_rd && i_reg_addr == 16'h05A8 |=> !o_reg_rdata[31])
        else $error("bit 31 set in sample 8 ns");
    // phase word carries only a legal slot code
    phase_code_a: assert property (i_reg_rd && i_reg_addr == 16'h05A4
        |=> o_reg_rdata[31:3] == 29'h0 && o_reg_rdata[2:0] <= 3'h4)
        else $error("bad phase word");
    unmapped_zero_a: assert property (i_reg_rd && !(i_reg_addr inside
        {16'h059C, 16'h05A0, 16'h05A4, 16'h05A8, 16'h05AC}) |=> o_reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    // reset is checked with no disable so it really fires
    reset_clears_a: assert property (disable iff (1'b0) i_rst
        |=> o_reg_rdata == 32'h0 && !o_reg_rvalid)
        else $error("reset did not clear read port");
    // main scenarios
    cover property (i_reg_rd && i_reg_addr == 16'h05A8);
    cover property (i_reg_rd && i_reg_addr == 16'h05B0);
    cover property (i_reg_wr);
endmodule // sample_regs_checker

// ### tb/event_source.sv
// far-side event input: toggles a unit's line on command
module event_source (
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // one-cycle toggle requests per unit
    input  wire logic [1:0] i_toggle,
    output logic      [1:0] o_event
);
    timeunit 1ns;
    timeprecision 1ps;
    // line level flips once per request, so rises and falls alternate
    always @(posedge i_mclk) begin
        if (i_rst)
            o_event <= 2'h0;
        else
            o_event <= o_event ^ i_toggle;
    end
endmodule // event_source

// ### tb/event_timestamp_sample_regs_test.sv
// self-checking bench for the seventh and eighth sample registers
bind event_timestamp_sample_regs sample_regs_checker sample_regs_checker_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
    .i_reg_wr(i_reg_wr), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid));
module event_timestamp_sample_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_mclk = 1'b0, i_rst = 1'b1, i_reg_rd = 1'b0, i_reg_wr = 1'b0;
    logic [1:0]  i_rearm = 2'h0, tog = 2'h0, prev;
    logic [29:0] i_tod_nsec = 30'h0;
    logic [31:0] i_tod_sec = 32'h0, i_unit_index_reg = 32'h0, i_reg_wdata = 32'h0;
    logic [15:0] i_reg_addr = 16'h0;
    logic [31:0] m_ns[2][2], m_s[2][2], m_ph[2][2];
    logic [3:0]  cnt[2];
    wire  [1:0]  i_event;
    wire  [31:0] o_reg_rdata;
    wire         o_reg_rvalid;
    integer      seed = 69800, bad_count = 0, checks = 0, cyc = 0;
    event_source event_source_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_toggle(tog),
        .o_event(i_event));
    event_timestamp_sample_regs #(.NUM_UNITS(2)) event_timestamp_sample_regs_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_event(i_event), .i_rearm(i_rearm),
        .i_tod_nsec(i_tod_nsec), .i_tod_sec(i_tod_sec), .i_unit_index_reg(i_unit_index_reg),
        .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid));
    always #2 i_mclk = ~i_mclk;
    // time base keeps moving so a stale capture shows
    always @(posedge i_mclk) begin
        i_tod_nsec <= 30'($random(seed));
        i_tod_sec <= $random(seed);
    end
    // reference: count changes per unit, keep the seventh and eighth
    always @(posedge i_mclk) begin
        cyc <= i_rst ? 0 : cyc + 1;
        prev <= i_rst ? 2'h0 : i_event;
        for (int u = 0; u < 2; u++) begin
            if (i_rst) begin
                cnt[u] <= 4'h0;
                for (int s = 0; s < 2; s++) begin
                    m_ns[u][s] <= 32'h0;
                    m_s[u][s] <= 32'h0;
                    m_ph[u][s] <= 32'h0;
                end
            end else if (i_rearm[u])
                cnt[u] <= 4'h0;
            else if (i_event[u] != prev[u] && cnt[u] < 4'h8) begin
                cnt[u] <= cnt[u] + 4'h1;
                if (cnt[u] >= 4'h6) begin
                    m_ns[u][cnt[u][0]] <= {1'b0, i_event[u], i_tod_nsec};
                    m_s[u][cnt[u][0]] <= i_tod_sec;
                    m_ph[u][cnt[u][0]] <= (cyc % 10) / 2;
                end
            end
        end
    end
    function automatic logic [31:0] expect_word(input int u, input logic [15:0] a);
        case (a)
            16'h059C: return m_ns[u][0];
            16'h05A0: return m_s[u][0];
            16'h05A4: return m_ph[u][0];
            16'h05A8: return m_ns[u][1];
            16'h05AC: return m_s[u][1];
            default:  return 32'h0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // answer to one read, looked at mid-cycle while it stands
    task automatic rd_chk(input int u, input logic [15:0] a);
        chk({31'h0, o_reg_rvalid}, 32'h1);
        chk(o_reg_rdata, expect_word(u, a));
    endtask
    // back-to-back reads of both units, unmapped word last; entered on an edge
    // request n is driven on the edge that takes request n-1
    task automatic read_all(input string name);
        logic [31:0] r;
        for (int n = 0; n <= 12; n++) begin
            if (n < 12) begin
                r = $random(seed);
                i_reg_addr <= 16'h059C + 16'(4 * (n % 6));
                i_reg_rd <= 1'b1;
                i_unit_index_reg <= {r[31:9], n >= 6, r[7:0]};
            end else
                i_reg_rd <= 1'b0;
            @(negedge i_mclk);
            if (n > 0)
                rd_chk((n - 1) / 6, 16'h059C + 16'(4 * ((n - 1) % 6)));
            @(posedge i_mclk);
        end
        $display("test %s done", name);
    endtask
    // gaps of one to four cycles between line changes
    task automatic fire(input int u, input int n);
        for (int k = 0; k < n; k++) begin
            tog <= 2'h1 << u;
            @(posedge i_mclk);
            tog <= 2'h0;
            repeat (1 + $unsigned($random(seed)) % 4) @(posedge i_mclk);
        end
        repeat (3) @(posedge i_mclk);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        read_all("reset");
        fire(0, 8);
        read_all("unit0");
        // writes everywhere must leave the samples alone
        i_reg_wr <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            i_reg_addr <= 16'h059C + 16'(4 * i);
            i_reg_wdata <= $random(seed);
            @(posedge i_mclk);
        end
        i_reg_wr <= 1'b0;
        fire(1, 8);
        read_all("unit1_writes");
        fire(0, 3);
        read_all("saturate");
        i_rearm <= 2'h1;
        @(posedge i_mclk);
        i_rearm <= 2'h0;
        fire(0, 8);
        read_all("rearm");
        report_and_stop;
    end
endmodule // event_timestamp_sample_regs_test
